// >>> inc/boot_clk_pkg.sv
// Package: constants, field layout and carrier types of the boot clock and watchdog block
//
// How it works
// - Config bit 7 low starts watchdog enabled
// - Reset loads watchdog enable from inverted bit 7
// - Config bit 4 inserts the clock noise filter
// - RC source, bit 3 high: full rate
// - RC source, bit 3 low: divide by two
// - Source field 11 RC, 00 crystal, 10 reserved
// - Unprogrammed configuration byte reads all ones
`default_nettype none

package boot_clk_pkg;

  // Avalon-MM byte offsets of the word registers
  localparam logic [3:0] CFG_BYTE_OFFSET = 4'h0;  // Boot configuration byte
  localparam logic [3:0] CTRL_OFFSET     = 4'h4;  // Run-time control
  localparam logic [3:0] STATUS_OFFSET   = 4'h8;  // Latched settings and state

  // Configuration byte field positions
  localparam int CFG_WDT_DIS_N_BIT  = 7;
  localparam int CFG_FILTER_BIT     = 4;
  localparam int CFG_FULL_RATE_BIT  = 3;
  localparam int CFG_SRC_HI_BIT     = 1;
  localparam int CFG_SRC_LO_BIT     = 0;

  // Unprogrammed value, and the bits that software may change
  localparam logic [7:0] CFG_ERASED_VALUE = 8'hFF;
  localparam logic [7:0] CFG_WRITE_MASK   = 8'h9B;

  // Control register fields
  localparam int CTRL_WDT_EN_BIT = 0;
  localparam int CTRL_RELOAD_BIT = 1;

  // Status register field positions
  localparam int STAT_SRC_LO_BIT     = 0;
  localparam int STAT_FULL_RATE_BIT  = 2;
  localparam int STAT_FILTER_BIT     = 3;
  localparam int STAT_RESERVED_BIT   = 4;
  localparam int STAT_RC_ACTIVE_BIT  = 5;

  // Clock source codes
  localparam logic [1:0] SRC_CRYSTAL  = 2'h0;
  localparam logic [1:0] SRC_RESERVED = 2'h2;
  localparam logic [1:0] SRC_RC       = 2'h3;

  // Noise filter: clock ticks closer than this are treated as glitches
  localparam int CLK_MHZ              = 200;
  localparam int FILTER_MIN_GAP_NS    = 40;
  localparam int FILTER_MIN_GAP_CYC   = (FILTER_MIN_GAP_NS * CLK_MHZ + 999) / 1000;

  // RC divide-by-two stage ratio
  localparam int RC_DIV_RATIO = 2;

  // Clock settings held from one reset to the next
  typedef struct packed {
    logic       clock_noise_filter_on;
    logic       rc_full_rate_select;
    logic [1:0] clk_src_sel;
  } clk_settings_t;

endpackage : boot_clk_pkg

`default_nettype wire

// >>> rtl/boot_clock_watchdog_config.sv
// Module: boot configuration byte, clock source selection and watchdog enable loading
`timescale 1ns/1ps
`default_nettype none

module boot_clock_watchdog_config
  import boot_clk_pkg::*;
#(
  parameter int FILTER_GAP = FILTER_MIN_GAP_CYC,
  parameter int DIV_RATIO  = RC_DIV_RATIO
)
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,

  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,

  // Oscillator ticks, one-cycle enables
  input  wire logic        i_rc_osc_tick,
  input  wire logic        i_xtal_tick,

  // System clock enable, watchdog enable and settings reload pulse
  output logic             o_sys_clk_en,
  output logic             o_run_watchdog_enable,
  output logic             o_clk_settings_reload
);

  // Overview
  // The configuration byte image sits behind the register bus and is
  // erased to all ones by i_reset, as an unprogrammed part would be.
  // The live clock settings and the watchdog enable never follow the
  // byte directly: they are loaded at reset, and again when software
  // asks for a reload, which stands in for a warm reset of the chip.
  // The clock path works on one-cycle tick enables, never on a derived
  // clock, so the whole block stays in the single i_clk domain.
  // Limitation: two oscillator ticks closer than one i_clk cycle merge
  // into one, so the oscillator models must run well below i_clk.
  // Byte enables 3:1 and write data 31:8 are ignored, since every
  // field sits in byte lane 0.

  // Refuse parameters the helper modules cannot serve; the helpers
  // check themselves too, but this message names the top parameter
  generate
    if (FILTER_GAP < 1 || DIV_RATIO < 2)
    begin : g_bad_param
      $error("boot_clock_watchdog_config: FILTER_GAP >= 1 and DIV_RATIO >= 2 required");
    end
  endgenerate

  // Configuration byte image; erased state is all ones
  logic [7:0]     boot_clock_watchdog_byte_q;
  // Settings held from the last reset or reload
  clk_settings_t  settings_q;
  // Run-time watchdog enable
  logic           run_watchdog_enable_q;
  // Software-requested reload, acts like a warm reset of this block
  logic           reload_q;
  // Bus answer stage
  logic           ack_q;
  logic [31:0]    readdata_q;
  // Clock path intermediates
  logic           rc_half_tick;
  logic           rc_tick;
  logic           src_tick;
  logic           filtered_tick;
  logic           sys_tick_q;
  logic           src_is_rc;
  logic           src_reserved;

  // Bus decode helpers
  logic           bus_req;
  logic           wr_take;
  logic           cfg_wr;       // Completing write to the configuration byte
  logic           ctrl_wr;      // Completing write to the control register
  logic           rd_sel_cfg;
  logic           rd_sel_ctrl;
  logic           rd_sel_stat;
  logic [31:0]    rd_value;

  // Named views of the configuration byte
  logic           cfg_watchdog_disable_n;
  logic           clock_noise_filter_on;
  logic           rc_full_rate_select;
  logic           clk_src_sel_hi;
  logic           clk_src_sel_lo;

  assign cfg_watchdog_disable_n = boot_clock_watchdog_byte_q[CFG_WDT_DIS_N_BIT];
  assign clock_noise_filter_on  = boot_clock_watchdog_byte_q[CFG_FILTER_BIT];
  assign rc_full_rate_select    = boot_clock_watchdog_byte_q[CFG_FULL_RATE_BIT];
  assign clk_src_sel_hi         = boot_clock_watchdog_byte_q[CFG_SRC_HI_BIT];
  assign clk_src_sel_lo         = boot_clock_watchdog_byte_q[CFG_SRC_LO_BIT];

  // Avalon-MM slave: one wait state, answer on the second edge
  // The wait state buys a full cycle for the read mux, so read data
  // leaves a flip-flop; the cost is two cycles per access, harmless
  // for registers that software touches only around boot.

  // A request is any read or write strobe
  assign bus_req = i_avs_read || i_avs_write;

  // Waitrequest drops in the cycle after the request is seen
  assign o_avs_waitrequest = bus_req && !ack_q;

  // A write takes effect only on the edge that completes it
  assign wr_take = i_avs_write && ack_q;

  // Writes that land, per register; byte lane 0 carries every field
  assign cfg_wr  = wr_take && rd_sel_cfg && i_avs_byteenable[0];
  assign ctrl_wr = wr_take && rd_sel_ctrl && i_avs_byteenable[0];

  // Ack stage toggles high for exactly one cycle per access
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      ack_q <= 1'b0;
    else
      ack_q <= bus_req && !ack_q;
  end

  // Address decode, shared by reads and writes
  always_comb
  begin
    rd_sel_cfg  = 1'b0;
    rd_sel_ctrl = 1'b0;
    rd_sel_stat = 1'b0;
    if (i_avs_address == CFG_BYTE_OFFSET)
      rd_sel_cfg = 1'b1;
    else if (i_avs_address == CTRL_OFFSET)
      rd_sel_ctrl = 1'b1;
    else if (i_avs_address == STATUS_OFFSET)
      rd_sel_stat = 1'b1;
  end

  // Read value; unmapped addresses and the reload bit read as zero
  always_comb
  begin
    rd_value = 32'h0000_0000;
    if (rd_sel_cfg)
      rd_value[7:0] = boot_clock_watchdog_byte_q;  // Reserved bits read as one
    else if (rd_sel_ctrl)
      rd_value[CTRL_WDT_EN_BIT] = run_watchdog_enable_q;
    else if (rd_sel_stat)
    begin
      rd_value[STAT_SRC_LO_BIT +: 2]   = settings_q.clk_src_sel;
      rd_value[STAT_FULL_RATE_BIT]     = settings_q.rc_full_rate_select;
      rd_value[STAT_FILTER_BIT]        = settings_q.clock_noise_filter_on;
      rd_value[STAT_RESERVED_BIT]      = src_reserved;
      rd_value[STAT_RC_ACTIVE_BIT]     = src_is_rc;
    end
  end

  // Read data captured while waitrequest is still high, so it stands
  // stable in the cycle the master samples it
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      readdata_q <= 32'h0000_0000;
    else if (i_avs_read && !ack_q)
      readdata_q <= rd_value;
  end

  assign o_avs_readdata = readdata_q;

  // Configuration byte image
  // Reserved bits are forced to one on every write, so a read always
  // shows the erased value in them, whatever software wrote there.

  // Power-up reset models the erased part; only documented bits are
  // writable, so reserved bits stay at one
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      boot_clock_watchdog_byte_q <= CFG_ERASED_VALUE;
    else if (cfg_wr)
      boot_clock_watchdog_byte_q <= (i_avs_writedata[7:0] & CFG_WRITE_MASK)
                                  | ~CFG_WRITE_MASK;
  end

  // Reset reloading
  // A reload takes the byte as it stands in the cycle of the pulse, so
  // the byte written by any earlier access is the one that is loaded.
  // Both loads share one pulse, so settings and watchdog never disagree.

  // Reload request from software; a one-cycle pulse, it never reads back
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      reload_q <= 1'b0;
    else
      reload_q <= ctrl_wr && i_avs_writedata[CTRL_RELOAD_BIT];
  end

  // Reload pulse shown outside, one cycle before the settings move
  assign o_clk_settings_reload = reload_q;

  // Clock settings follow the byte only at reset or reload; a byte
  // rewritten mid-run cannot glitch the live clock path
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      settings_q.clock_noise_filter_on <= CFG_ERASED_VALUE[CFG_FILTER_BIT];
      settings_q.rc_full_rate_select   <= CFG_ERASED_VALUE[CFG_FULL_RATE_BIT];
      settings_q.clk_src_sel           <= CFG_ERASED_VALUE[CFG_SRC_HI_BIT:CFG_SRC_LO_BIT];
    end
    else if (reload_q)
    begin
      settings_q.clock_noise_filter_on <= clock_noise_filter_on;
      settings_q.rc_full_rate_select   <= rc_full_rate_select;
      settings_q.clk_src_sel           <= {clk_src_sel_hi, clk_src_sel_lo};
    end
  end

  // Watchdog enable is the inverse of the config disable bit after
  // every reset; software may change it afterwards
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      run_watchdog_enable_q <= ~CFG_ERASED_VALUE[CFG_WDT_DIS_N_BIT];
    else if (reload_q)
      run_watchdog_enable_q <= ~cfg_watchdog_disable_n;
    else if (ctrl_wr)
      run_watchdog_enable_q <= i_avs_writedata[CTRL_WDT_EN_BIT];
  end

  // Watchdog enable leaves the block straight from its flip-flop
  assign o_run_watchdog_enable = run_watchdog_enable_q;

  // Clock path
  // Order is source mux, then filter, then one output flip-flop. The
  // divider counts RC ticks all the time, so switching to the halved
  // rate by a reload can give one short first period afterwards.

  // Source decode; reserved codes fall back to the internal RC, since
  // it needs no external part and the chip always gets a clock.
  // Status bit 4 lets software see that such a code was latched.
  always_comb
  begin
    src_is_rc    = 1'b1;
    src_reserved = 1'b0;
    case (settings_q.clk_src_sel)
      SRC_RC:      src_is_rc = 1'b1;
      SRC_CRYSTAL: src_is_rc = 1'b0;
      default:
      begin
        src_is_rc    = 1'b1;
        src_reserved = 1'b1;
      end
    endcase
  end

  // Divide-by-two stage on the RC oscillator
  tick_divider #(
    .RATIO   (DIV_RATIO)
  ) u_rc_div (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_tick  (i_rc_osc_tick),
    .o_tick  (rc_half_tick)
  );

  // Full rate bypasses the divider, otherwise the halved rate is used
  assign rc_tick = settings_q.rc_full_rate_select ? i_rc_osc_tick
                                                  : rc_half_tick;

  // Source mux between RC and crystal
  assign src_tick = src_is_rc ? rc_tick : i_xtal_tick;

  // Noise filter on the selected clock
  tick_noise_filter #(
    .MIN_GAP (FILTER_GAP)
  ) u_filter (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_tick  (src_tick),
    .o_tick  (filtered_tick)
  );

  // Filter in or bypassed; the output enable is registered so that the
  // enable seen by the rest of the chip never carries mux glitches.
  // The cost is one cycle of latency from oscillator tick to enable.
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      sys_tick_q <= 1'b0;
    else if (settings_q.clock_noise_filter_on)
      sys_tick_q <= filtered_tick;
    else
      sys_tick_q <= src_tick;
  end

  assign o_sys_clk_en = sys_tick_q;

endmodule : boot_clock_watchdog_config

`default_nettype wire

// >>> rtl/tick_divider.sv
// Module: divides a stream of one-cycle tick enables by a fixed ratio
`timescale 1ns/1ps
`default_nettype none

module tick_divider
  import boot_clk_pkg::*;
#(
  parameter int RATIO = RC_DIV_RATIO
)
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Tick in and out
  input  wire logic i_tick,
  output logic      o_tick
);

  localparam int CW = (RATIO > 2) ? $clog2(RATIO) : 1;

  // Refuse ratios the counter cannot serve
  generate
    if (RATIO < 2)
    begin : g_bad_ratio
      $error("tick_divider: RATIO must be at least 2");
    end
  endgenerate

  logic [CW-1:0] count_q;  // Input ticks seen in this output period

  // Count input ticks and wrap at the ratio
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      count_q <= '0;
    else if (i_tick)
      count_q <= (count_q == CW'(RATIO - 1)) ? '0 : count_q + 1'b1;
  end

  // One output tick on the last input tick of each period
  assign o_tick = i_tick && (count_q == CW'(RATIO - 1));

endmodule : tick_divider

`default_nettype wire

// >>> rtl/tick_noise_filter.sv
// Module: drops clock ticks that follow the last good tick too closely
`timescale 1ns/1ps
`default_nettype none

module tick_noise_filter
  import boot_clk_pkg::*;
#(
  parameter int MIN_GAP = FILTER_MIN_GAP_CYC
)
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Tick in and filtered tick out
  input  wire logic i_tick,
  output logic      o_tick
);

  localparam int CW = $clog2(MIN_GAP + 1);

  // Refuse a gap the counter cannot serve
  generate
    if (MIN_GAP < 1)
    begin : g_bad_gap
      $error("tick_noise_filter: MIN_GAP must be at least 1");
    end
  endgenerate

  logic [CW-1:0] gap_q;  // Cycles since the last accepted tick, saturating

  // A tick passes only once the gap has run out
  assign o_tick = i_tick && (gap_q >= CW'(MIN_GAP));

  // Restart the gap on each accepted tick; glitches do not restart it
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      gap_q <= CW'(MIN_GAP);
    else if (o_tick)
      gap_q <= CW'(1);
    else if (gap_q < CW'(MIN_GAP))
      gap_q <= gap_q + 1'b1;
  end

endmodule : tick_noise_filter

`default_nettype wire

// >>> tb/boot_clock_watchdog_config_monitor.sv
// Port checker of the boot clock and watchdog block
`timescale 1ns/1ps
`default_nettype none

module boot_clock_watchdog_config_monitor
  import boot_clk_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset,
  // Register bus
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // Ticks and enables
  input wire logic        i_rc_osc_tick,
  input wire logic        i_xtal_tick,
  input wire logic        o_sys_clk_en,
  input wire logic        o_run_watchdog_enable,
  input wire logic        o_clk_settings_reload
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  logic ctrl_wr;     // Control write completing with byte 0 enabled
  logic reload_wr;   // Same, with the reload bit set
  logic req;         // Any bus request
  assign req = i_avs_read || i_avs_write;
  assign ctrl_wr = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
                   && i_avs_address == CTRL_OFFSET;
  assign reload_wr = ctrl_wr && i_avs_writedata[CTRL_RELOAD_BIT];

  // Bus handshake: exactly one wait state, none when idle
  property p_wait_first; req && !$past(req) |-> o_avs_waitrequest; endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait state");
  property p_wait_end; req && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
  a_wait_end: assert property (p_wait_end) else $error("wait state too long");
  property p_idle; !req |-> !o_avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait while idle");

  // Erased defaults right after reset: watchdog off
  property p_reset;
    $fell(i_reset) |-> !o_run_watchdog_enable && !o_sys_clk_en && !o_clk_settings_reload;
  endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");

  // Reload is a single pulse, caused only by a control write
  property p_reload_pulse; o_clk_settings_reload |=> !o_clk_settings_reload; endproperty
  a_reload_pulse: assert property (p_reload_pulse) else $error("long reload");
  property p_reload_cause;
    o_clk_settings_reload |-> $past(reload_wr) || $past(reload_wr, 2);
  endproperty
  a_reload_cause: assert property (p_reload_cause) else $error("stray reload");

  // Watchdog enable moves only on reload or a software control write
  property p_wdt_hold;
    $changed(o_run_watchdog_enable)
      |-> $past(o_clk_settings_reload) || $past(ctrl_wr) || $past(ctrl_wr, 2);
  endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog moved");

  // Every system tick has a source tick one cycle earlier
  property p_clk_cause; o_sys_clk_en |-> $past(i_rc_osc_tick) || $past(i_xtal_tick); endproperty
  a_clk_cause: assert property (p_clk_cause) else $error("tick without source");

  // Reserved byte bits read as one
  property p_cfg_read;
    i_avs_read && !o_avs_waitrequest && i_avs_address == CFG_BYTE_OFFSET
      |-> o_avs_readdata[31:8] == 24'h0 && o_avs_readdata[6:5] == 2'h3 && o_avs_readdata[2];
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("reserved bits wrong");

  // Status flags agree with the latched source code
  property p_stat_read;
    i_avs_read && !o_avs_waitrequest && i_avs_address == STATUS_OFFSET
      |-> o_avs_readdata[STAT_RC_ACTIVE_BIT] == (o_avs_readdata[1:0] != SRC_CRYSTAL)
      && o_avs_readdata[STAT_RESERVED_BIT]
         == (o_avs_readdata[1:0] == SRC_RESERVED || o_avs_readdata[1:0] == 2'h1);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status flags wrong");
endmodule // boot_clock_watchdog_config_monitor

`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench of the boot clock and watchdog block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %0h want %0h", $time, g, e); end end

module tb;
  import boot_clk_pkg::*;
  localparam int GAP = 4;  // Short filter gap so RC ticks 3 apart get thinned
  // Design inputs
  logic        i_clk, i_reset, i_avs_read, i_avs_write, i_rc_osc_tick, i_xtal_tick;
  logic [3:0]  i_avs_address, i_avs_byteenable;
  logic [31:0] i_avs_writedata;
  // Design outputs
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest, o_sys_clk_en, o_run_watchdog_enable, o_clk_settings_reload;
  // Bench state
  logic [31:0] rd_q[$], exp_w;   // Expected read data, oldest first
  int          miscompares, tests_run, ncnt, c0;
  int          seed = 32'h25D0D94D;
  logic [7:0]  d, r, p;          // Written byte, random bits, latched byte
  logic [7:0]  tab [7] = '{8'h0B, 8'h03, 8'h1B, 8'h00, 8'h10, 8'h0A, 8'h09};
  int          cnt [7] = '{24, 12, 12, 18, 18, 24, 24};  // Ticks out per 72 cycles

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  boot_clock_watchdog_config #(.FILTER_GAP(GAP), .DIV_RATIO(2)) i_boot_clock_watchdog_config (
    .i_clk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_rc_osc_tick, .i_xtal_tick,
    .o_sys_clk_en, .o_run_watchdog_enable, .o_clk_settings_reload);

  // Status word expected for a latched byte; reserved codes 01 and 10 fall back to RC
  function automatic logic [31:0] stat(input logic [7:0] c);
    return {26'h0, c[1:0] != SRC_CRYSTAL, c[1:0] == SRC_RESERVED || c[1:0] == 2'h1,
            c[4], c[3], c[1:0]};
  endfunction

  // One bus cycle, held until waitrequest is sampled low at a rising edge;
  // no limit of its own, the timeout ends a hang
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be, input logic [31:0] e);
    @(posedge i_clk);
    if (!we)
      rd_q.push_back(e);
    i_avs_address    <= a;
    i_avs_writedata  <= wd;
    i_avs_byteenable <= be;
    i_avs_read       <= !we;
    i_avs_write      <= we;
    do
      @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0);
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, 4'hF, 32'h0);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF, e);
  endtask

  // Completed reads are checked in the cycle their data stands
  always @(negedge i_clk)
    if (i_avs_read && o_avs_waitrequest === 1'b0)
    begin
      if (rd_q.size() == 0)
      begin
        miscompares++;
        $display("mismatch at %0t: read without expectation", $time);
      end
      else
      begin
        exp_w = rd_q.pop_front();
        `CHK(o_avs_readdata, exp_w)
      end
    end

  // System tick counter, sampled mid-cycle to stay clear of the edge
  always @(negedge i_clk)
    if (o_sys_clk_en === 1'b1)
      ncnt++;

  // RC ticks every 3 cycles, crystal every 4, then count what came out
  task automatic ticks(input int e);
    c0 = ncnt;
    for (int i = 0; i < 75; i++)
    begin
      @(posedge i_clk);
      i_rc_osc_tick <= (i % 3 == 0) && i < 72;
      i_xtal_tick   <= (i % 4 == 0) && i < 72;
    end
    @(negedge i_clk);
    `CHK(ncnt - c0, e)
  endtask

  // Let a reload or control write land, then look at the watchdog enable
  task automatic wdt_chk(input logic e);
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    `CHK(o_run_watchdog_enable, e)
  endtask

  // Reset seen at six rising edges, asserted just after an edge
  task automatic do_reset();
    i_reset <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
  endtask

  task automatic print_verdict();
    if (rd_q.size() != 0)
    begin
      miscompares++;
      $display("mismatch at %0t: %0d reads never answered", $time, rd_q.size());
    end
    $display("counts: %0d compared, %0d mismatched", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {i_avs_read, i_avs_write, i_rc_osc_tick, i_xtal_tick} = 4'h0;
    i_avs_address = 4'h0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'h0;
    p = CFG_ERASED_VALUE;
    do_reset();
    rd(CFG_BYTE_OFFSET, 32'hFF);
    rd(STATUS_OFFSET, stat(p));
    rd(4'hC, 32'h0);
    rd(CTRL_OFFSET, 32'h0);
    $display("test power-up done");
    for (int k = 0; k < 7; k++)
    begin
      r = 8'($random(seed));
      d = tab[k] | (r & 8'hE4);
      wr(CFG_BYTE_OFFSET, {24'h0, d});
      rd(CFG_BYTE_OFFSET, {24'h0, d | ~CFG_WRITE_MASK});
      rd(STATUS_OFFSET, stat(p));
      wr(CTRL_OFFSET, 32'h2);
      wdt_chk(~d[7]);
      rd(CTRL_OFFSET, {31'h0, ~d[7]});
      rd(STATUS_OFFSET, stat(d));
      p = d;
      ticks(cnt[k]);
      $display("test config %0h done", d);
    end
    // Refused writes: no byte enable, read-only status, unmapped place
    bus(1'b1, CTRL_OFFSET, {31'h0, d[7]}, 4'h0, 32'h0);
    rd(CTRL_OFFSET, {31'h0, ~d[7]});
    wr(CTRL_OFFSET, 32'h0);
    wdt_chk(1'b0);
    wr(CTRL_OFFSET, 32'h1);
    wdt_chk(1'b1);
    wr(STATUS_OFFSET, 32'h0);
    rd(STATUS_OFFSET, stat(d));
    wr(4'hC, 32'hFF);
    rd(4'hC, 32'h0);
    $display("test refusals done");
    // Second reset erases the byte: filter on, full-rate RC, watchdog off
    do_reset();
    rd(CFG_BYTE_OFFSET, 32'hFF);
    rd(STATUS_OFFSET, stat(CFG_ERASED_VALUE));
    wdt_chk(1'b0);
    ticks(12);
    $display("test second reset done");
    print_verdict();
  end

  // Whole run needs under a thousand cycles; 20000 leaves ample margin
  initial
  begin
    #100000;
    miscompares++;
    $display("mismatch at %0t: timeout", $time);
    print_verdict();
  end
endmodule // tb

bind boot_clock_watchdog_config boot_clock_watchdog_config_monitor i_mon (
  .i_clk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_rc_osc_tick, .i_xtal_tick,
  .o_sys_clk_en, .o_run_watchdog_enable, .o_clk_settings_reload);

`default_nettype wire
